/* rtl/cqf_pkg.sv */
// Package: register map, record layout and timing of the CAN transmit queue front end
package cqf_pkg;
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_PERIOD     = 8'h04;
   localparam logic [7:0]  REG_ID         = 8'h08;
   localparam logic [7:0]  REG_KLEN       = 8'h0C;
   localparam logic [7:0]  REG_DLO        = 8'h10;
   localparam logic [7:0]  REG_DHI        = 8'h14;
   localparam logic [7:0]  REG_SUBMIT     = 8'h18;
   localparam logic [7:0]  REG_STATUS     = 8'h1C;
   localparam logic [7:0]  REG_INT_STAT   = 8'h20;
   localparam logic [7:0]  REG_INT_MASK   = 8'h24;
   localparam int unsigned CTRL_PER_BIT   = 0;
   localparam int unsigned CTRL_DEPTH_LSB = 4;
   localparam int unsigned DEPTH_W        = 4;
   localparam int unsigned Q_DEPTH        = 8;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0080;
   localparam int unsigned KLEN_LEN_LSB   = 8;
   localparam logic [7:0]  KIND_DATA      = 8'h00;
   localparam logic [7:0]  KIND_REMOTE    = 8'h01;
   localparam int unsigned EXT_FLAG_BIT   = 29;
   localparam int unsigned STD_ID_W       = 11;
   localparam int unsigned EXT_ID_W       = 29;
   localparam logic [7:0]  MAX_LEN        = 8'h08;
   localparam logic [31:0] RECORD_SIZE    = 32'h0000_0018;
   localparam int unsigned CLK_PERIOD_PS  = 5000;
   localparam int unsigned PERIOD_DEF_US  = 1000;
   localparam int unsigned PERIOD_DEF_CYC = PERIOD_DEF_US * 1000 * 1000 / CLK_PERIOD_PS;
   localparam logic [1:0]  RES_OK         = 2'h0;
   localparam logic [1:0]  RES_SIZE       = 2'h1;
   localparam logic [1:0]  RES_OVF        = 2'h2;
   localparam logic [1:0]  RES_KIND       = 2'h3;
   localparam int unsigned INT_DONE       = 0;
   localparam int unsigned INT_OVF        = 1;
   localparam int unsigned INT_REJ        = 2;
   localparam int unsigned INT_W          = 3;
   localparam int unsigned ST_COMPLETE    = 0;
   localparam int unsigned ST_BUSY        = 1;
   localparam int unsigned ST_EMPTY       = 2;
   localparam int unsigned ST_COUNT_LSB   = 4;
   localparam int unsigned ST_RESULT_LSB  = 8;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_WAIT = 2'b10
   } cqf_tx_e;

   typedef struct packed {
      logic        rtr;
      logic        ext;
      logic [28:0] ident;
      logic [3:0]  dlc;
      logic [63:0] data;
   } cqf_frame_s;

   localparam int unsigned FRAME_W = $bits(cqf_frame_s);
endpackage : cqf_pkg

/* rtl/cqf_q_if.sv */
// Interface: transmit queue control and data between front end and queue store
`timescale 1ns/1ps
interface cqf_q_if #(
   parameter int unsigned W  = 99,
   parameter int unsigned CW = 4
);
   logic          push;
   logic          pop;
   logic [W-1:0]  wdata;
   logic [W-1:0]  rdata;
   logic [CW-1:0] cfg_depth;
   logic [CW-1:0] count;
   logic          full;
   logic          empty;

   modport ctl (output push, pop, wdata, cfg_depth, input rdata, count, full, empty);
   modport mem (input push, pop, wdata, cfg_depth, output rdata, count, full, empty);
endinterface : cqf_q_if

/* rtl/cqf_queue.sv */
// Transmit queue store: FIFO with runtime depth and a zero-depth overwrite slot
`timescale 1ns/1ps
module cqf_queue #(
   parameter int unsigned W     = 99,
   parameter int unsigned DEPTH = 8,
   parameter int unsigned CW    = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   cqf_q_if.mem     q
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wr;
      logic [PW-1:0]           rd;
      logic [CW-1:0]           count;
   } cqf_qstate_s;

   cqf_qstate_s s_q;
   cqf_qstate_s s_d;

   function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
      nxt = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : nxt

   assign q.rdata = s_q.mem[s_q.rd];
   assign q.count = s_q.count;
   assign q.empty = (s_q.count == '0);
   assign q.full  = (q.cfg_depth != '0) && (s_q.count >= q.cfg_depth);

   always_comb begin
      s_d = s_q;
      if (q.cfg_depth == '0) begin
         // Single slot: a new item simply replaces the pending one
         if (q.pop) begin
            s_d.count = '0;
         end
         if (q.push) begin
            s_d.mem[s_q.rd] = q.wdata;
            s_d.count       = CW'(1);
         end
      end else begin
         // First in, first out
         if (q.push) begin
            s_d.mem[s_q.wr] = q.wdata;
            s_d.wr          = nxt(s_q.wr);
         end
         if (q.pop) begin
            s_d.rd = nxt(s_q.rd);
         end
         s_d.count = s_q.count + CW'(q.push) - CW'(q.pop);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : cqf_queue

/* rtl/cqf_top.sv */
// CAN transmit queue front end: AHB-Lite registers, queue, periodic and one-shot sender
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - A submit only enqueues and the bus write completes without waiting
// - Submit size must equal the record size, otherwise the record is rejected
// - Complete rises only when queue is empty and last frame was sent
// - Complete stays set until the next enqueue, which clears it
// - Complete reads true from reset before anything is enqueued
// - Periodic mode takes one queued item at each period boundary reached while the sender is idle
// - Periodic mode with empty queue resends the previous frame
// - Full queue discards the submission and reports overflow
// - Depth zero overwrites the pending item and never reports overflow
// - Frame kind is checked after the record size and steers only the remote flag and which payload bytes are sent
// - Kind 0 goes out as a data frame
// - Kind 1 goes out as a remote frame without data bytes
// - Identifier is a 32-bit word, bit 29 flags an extended identifier
// - Flag clear sends 11-bit identifier, flag set sends 29-bit identifier
// - Data frame sends exactly length bytes of the eight-byte payload
// - Remote frame ignores payload and sends length as its length code
// - Success only after the remote acknowledge on tx_done
module cqf_top #(
   parameter int unsigned DEPTH      = cqf_pkg::Q_DEPTH,
   parameter logic [31:0] PERIOD_CYC = 32'(cqf_pkg::PERIOD_DEF_CYC)
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   output logic             irq,
   output logic             tx_valid,
   output logic [28:0]      tx_ident,
   output logic             tx_ext,
   output logic             tx_rtr,
   output logic [3:0]       tx_dlc,
   output logic [63:0]      tx_data,
   input  wire logic        tx_done
);
   localparam int unsigned CW = cqf_pkg::DEPTH_W;

   typedef struct packed {
      cqf_pkg::cqf_tx_e         tx;
      logic                     periodic;
      logic [CW-1:0]            depth;
      logic [31:0]              period;
      logic [31:0]              tick_cnt;
      logic [31:0]              id;
      logic [7:0]               kind;
      logic [7:0]               len;
      logic [63:0]              data;
      logic                     complete;
      logic [1:0]               result;
      logic [cqf_pkg::INT_W-1:0] int_stat;
      logic [cqf_pkg::INT_W-1:0] int_mask;
      logic                     irq;
      cqf_pkg::cqf_frame_s      last;
      logic                     have_last;
      cqf_pkg::cqf_frame_s      out;
      logic                     tx_valid;
      logic [7:0]               addr;
      logic                     wr_pend;
      logic                     rd_pend;
      logic [31:0]              hrdata;
      logic                     hreadyout;
   } cqf_state_s;

   cqf_state_s                s_q;
   cqf_state_s                s_d;
   cqf_pkg::cqf_frame_s       new_f;
   logic                      addr_ok;
   logic                      sub;
   logic                      size_ok;
   logic                      kind_ok;
   logic                      tick;
   logic                      send_new;
   logic                      send_last;
   logic                      done_empty;
   logic [cqf_pkg::INT_W-1:0] ev;

   cqf_q_if #(.W(cqf_pkg::FRAME_W), .CW(CW)) q ();

   cqf_queue #(.W(cqf_pkg::FRAME_W), .DEPTH(DEPTH), .CW(CW)) u_queue (
      .hclk    (hclk),
      .hresetn (hresetn),
      .q       (q.mem)
   );

   // Turns the staged record into the frame that goes on the wire
   function automatic cqf_pkg::cqf_frame_s build(input logic [31:0] id, input logic [7:0] kind,
                                                 input logic [7:0] len, input logic [63:0] d);
      cqf_pkg::cqf_frame_s f;
      f.rtr = (kind == cqf_pkg::KIND_REMOTE);
      f.ext = id[cqf_pkg::EXT_FLAG_BIT];
      f.ident = f.ext ? id[cqf_pkg::EXT_ID_W-1:0]
                      : {18'h0, id[cqf_pkg::STD_ID_W-1:0]};
      f.dlc = len[3:0];
      f.data = '0;
      for (int i = 0; i < 8; i++) begin
         if (!f.rtr && (8'(i) < len)) begin
            f.data[8*i +: 8] = d[8*i +: 8];
         end
      end
      build = f;
   endfunction : build

   assign q.wdata     = new_f;
   assign q.cfg_depth = s_q.depth;
   assign hreadyout   = s_q.hreadyout;
   assign hrdata      = s_q.hrdata;
   assign hresp       = 1'b0;
   assign irq         = s_q.irq;
   assign tx_valid    = s_q.tx_valid;
   assign tx_ident    = s_q.out.ident;
   assign tx_ext      = s_q.out.ext;
   assign tx_rtr      = s_q.out.rtr;
   assign tx_dlc      = s_q.out.dlc;
   assign tx_data     = s_q.out.data;

   always_comb begin
      s_d       = s_q;
      q.push    = 1'b0;
      q.pop     = 1'b0;
      ev        = '0;
      tick      = 1'b0;
      send_new  = 1'b0;
      send_last = 1'b0;
      new_f     = build(s_q.id, s_q.kind, s_q.len, s_q.data);
      // Bus address phase
      addr_ok   = hsel & hready & htrans[1];
      s_d.wr_pend = addr_ok & hwrite;
      s_d.rd_pend = addr_ok & ~hwrite;
      if (addr_ok) begin
         s_d.addr = haddr[7:0];
      end
      if (addr_ok & ~hwrite) begin
         s_d.hreadyout = 1'b0;
      end
      // Write data phase
      sub     = s_q.wr_pend && (s_q.addr == cqf_pkg::REG_SUBMIT);
      size_ok = (hwdata == cqf_pkg::RECORD_SIZE);
      kind_ok = ((s_q.kind == cqf_pkg::KIND_DATA) || (s_q.kind == cqf_pkg::KIND_REMOTE))
                && (s_q.len <= cqf_pkg::MAX_LEN);
      done_empty = (s_q.tx == cqf_pkg::TX_WAIT) && tx_done && q.empty;
      if (s_q.wr_pend) begin
         case (s_q.addr)
            cqf_pkg::REG_CTRL: begin
               s_d.periodic = hwdata[cqf_pkg::CTRL_PER_BIT];
               s_d.depth    = hwdata[cqf_pkg::CTRL_DEPTH_LSB +: CW];
               if (s_d.depth > CW'(DEPTH)) begin
                  s_d.depth = CW'(DEPTH);
               end
            end
            cqf_pkg::REG_PERIOD: begin
               s_d.period = (hwdata == '0) ? 32'h0000_0001 : hwdata;
            end
            cqf_pkg::REG_ID: begin
               s_d.id = hwdata;
            end
            cqf_pkg::REG_KLEN: begin
               s_d.kind = hwdata[7:0];
               s_d.len  = hwdata[cqf_pkg::KLEN_LEN_LSB +: 8];
            end
            cqf_pkg::REG_DLO: begin
               s_d.data[31:0] = hwdata;
            end
            cqf_pkg::REG_DHI: begin
               s_d.data[63:32] = hwdata;
            end
            cqf_pkg::REG_INT_MASK: begin
               s_d.int_mask = hwdata[cqf_pkg::INT_W-1:0];
            end
            cqf_pkg::REG_SUBMIT: begin
               if (!size_ok) begin
                  s_d.result = cqf_pkg::RES_SIZE;
                  ev[cqf_pkg::INT_REJ] = 1'b1;
               end else if (!kind_ok) begin
                  s_d.result = cqf_pkg::RES_KIND;
                  ev[cqf_pkg::INT_REJ] = 1'b1;
               end else if ((s_q.depth != '0) && q.full) begin
                  s_d.result = cqf_pkg::RES_OVF;
                  ev[cqf_pkg::INT_OVF] = 1'b1;
               end else begin
                  q.push       = 1'b1;
                  s_d.result   = cqf_pkg::RES_OK;
                  s_d.complete = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Read data phase, one wait state
      if (s_q.rd_pend) begin
         s_d.hreadyout = 1'b1;
         case (s_q.addr)
            cqf_pkg::REG_CTRL:     s_d.hrdata = {24'h0, s_q.depth, 3'h0, s_q.periodic};
            cqf_pkg::REG_PERIOD:   s_d.hrdata = s_q.period;
            cqf_pkg::REG_ID:       s_d.hrdata = s_q.id;
            cqf_pkg::REG_KLEN:     s_d.hrdata = {16'h0, s_q.len, s_q.kind};
            cqf_pkg::REG_DLO:      s_d.hrdata = s_q.data[31:0];
            cqf_pkg::REG_DHI:      s_d.hrdata = s_q.data[63:32];
            cqf_pkg::REG_STATUS:   s_d.hrdata = {22'h0, s_q.result, q.count, 1'b0, q.empty,
                                                 s_q.tx_valid, s_q.complete};
            cqf_pkg::REG_INT_STAT: begin
               s_d.hrdata   = {29'h0, s_q.int_stat};
               s_d.int_stat = '0;
            end
            cqf_pkg::REG_INT_MASK: s_d.hrdata = {29'h0, s_q.int_mask};
            default:               s_d.hrdata = '0;
         endcase
      end
      // Period divider
      if (s_q.periodic) begin
         if (s_q.tick_cnt >= s_q.period - 32'h0000_0001) begin
            tick         = 1'b1;
            s_d.tick_cnt = '0;
         end else begin
            s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
         end
      end else begin
         s_d.tick_cnt = '0;
      end
      // Sender
      case (s_q.tx)
         cqf_pkg::TX_IDLE: begin
            if (!s_q.periodic || tick) begin
               if (!q.empty) begin
                  q.pop    = 1'b1;
                  send_new = 1'b1;
               end else if (s_q.periodic && s_q.have_last) begin
                  send_last = 1'b1;
               end
            end
            if (send_new) begin
               s_d.out       = q.rdata;
               s_d.last      = q.rdata;
               s_d.have_last = 1'b1;
            end else if (send_last) begin
               s_d.out = s_q.last;
            end
            if (send_new || send_last) begin
               s_d.tx_valid = 1'b1;
               s_d.tx       = cqf_pkg::TX_WAIT;
            end
         end
         cqf_pkg::TX_WAIT: begin
            if (tx_done) begin
               s_d.tx_valid = 1'b0;
               s_d.tx       = cqf_pkg::TX_IDLE;
               if (q.empty && !q.push) begin
                  s_d.complete = 1'b1;
                  ev[cqf_pkg::INT_DONE] = 1'b1;
               end
            end
         end
         default: begin
            s_d.tx       = cqf_pkg::TX_IDLE;
            s_d.tx_valid = 1'b0;
         end
      endcase
      s_d.int_stat = s_d.int_stat | ev;
      s_d.irq      = |(s_d.int_stat & s_d.int_mask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q           <= '0;
         s_q.tx        <= cqf_pkg::TX_IDLE;
         s_q.depth     <= cqf_pkg::CTRL_RESET[cqf_pkg::CTRL_DEPTH_LSB +: CW];
         s_q.period    <= PERIOD_CYC;
         s_q.complete  <= 1'b1;
         s_q.hreadyout <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_submit_now;
      sub && size_ok && kind_ok && ((s_q.depth == '0) || !q.full) |-> q.push && hreadyout;
   endproperty
   a_submit_now: assert property (p_submit_now) else $error("valid submit not taken at once");

   property p_size;
      sub && !size_ok |-> !q.push ##1 (s_q.result == cqf_pkg::RES_SIZE);
   endproperty
   a_size: assert property (p_size) else $error("bad record size accepted");

   property p_rise;
      $rose(s_q.complete) |-> $past(done_empty);
   endproperty
   a_rise: assert property (p_rise) else $error("complete rose without final send");

   property p_clear;
      q.push |=> !s_q.complete;
   endproperty
   a_clear: assert property (p_clear) else $error("complete not cleared by enqueue");

   property p_periodic_pop;
      tick && (s_q.tx == cqf_pkg::TX_IDLE) && !q.empty |-> q.pop ##1 tx_valid;
   endproperty
   a_periodic_pop: assert property (p_periodic_pop) else $error("no fetch at period");

   property p_repeat;
      tick && (s_q.tx == cqf_pkg::TX_IDLE) && q.empty && s_q.have_last
         |=> tx_valid && (s_q.out == $past(s_q.last));
   endproperty
   a_repeat: assert property (p_repeat) else $error("previous frame not resent");

   property p_ovf;
      sub && size_ok && kind_ok && (s_q.depth != '0) && q.full
         |-> !q.push ##1 s_q.int_stat[cqf_pkg::INT_OVF];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged");

   property p_zero;
      sub && (s_q.depth == '0) |=> s_q.result != cqf_pkg::RES_OVF;
   endproperty
   a_zero: assert property (p_zero) else $error("overflow at depth zero");

   property p_std;
      tx_valid && !tx_ext |-> tx_ident[28:11] == '0;
   endproperty
   a_std: assert property (p_std) else $error("standard id wider than 11 bits");

   property p_remote;
      tx_valid && tx_rtr |-> tx_data == '0;
   endproperty
   a_remote: assert property (p_remote) else $error("remote frame carries data");

   property p_hold;
      tx_valid && !tx_done |=> tx_valid && $stable(tx_ident) && $stable(tx_data);
   endproperty
   a_hold: assert property (p_hold) else $error("frame dropped before acknowledge");

   c_repeat: cover property (tick && q.empty && s_q.have_last && (s_q.tx == cqf_pkg::TX_IDLE));
   c_ovf: cover property (ev[cqf_pkg::INT_OVF]);
   c_done: cover property ($rose(s_q.complete));
   c_zero: cover property (sub && (s_q.depth == '0) && !q.empty);
endmodule : cqf_top

/* verification/cqf_can_node.sv */
// Remote CAN node model: acknowledges each presented frame after a set delay
`timescale 1ns/1ps
module cqf_can_node (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          tx_valid,
   input  wire logic [28:0]   tx_ident,
   input  wire logic          tx_ext,
   input  wire logic          tx_rtr,
   input  wire logic [3:0]    tx_dlc,
   input  wire logic [63:0]   tx_data,
   input  wire logic [7:0]    ack_dly,
   output logic               tx_done,
   output logic [7:0]         n_sent,
   output cqf_pkg::cqf_frame_s last_f
);
   logic [7:0] cnt_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_done <= 1'b0;
         cnt_q   <= 8'h00;
         n_sent  <= 8'h00;
         last_f  <= '0;
      end else if (tx_done) begin
         tx_done <= 1'b0;
         cnt_q   <= 8'h00;
      end else if (tx_valid) begin
         cnt_q <= cnt_q + 8'h01;
         if (cnt_q >= ack_dly) begin
            tx_done <= 1'b1;
            n_sent  <= n_sent + 8'h01;
            last_f  <= {tx_rtr, tx_ext, tx_ident, tx_dlc, tx_data};
         end
      end
   end
endmodule : cqf_can_node

/* verification/cqf_top_tb.sv */
// Testbench: register-level tests of the CAN transmit queue front end
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end
module cqf_top_tb;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic        tx_valid, tx_ext, tx_rtr, tx_done;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [28:0] tx_ident;
   logic [3:0]  tx_dlc;
   logic [63:0] tx_data;
   logic [7:0]  ack_dly, n_sent, base;
   cqf_pkg::cqf_frame_s last_f;
   int          errors;
   int          checks_done;

   cqf_top #(.DEPTH(8), .PERIOD_CYC(32'h0000_0014)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
      .tx_valid(tx_valid), .tx_ident(tx_ident), .tx_ext(tx_ext), .tx_rtr(tx_rtr),
      .tx_dlc(tx_dlc), .tx_data(tx_data), .tx_done(tx_done));
   cqf_can_node u_node (
      .hclk(hclk), .hresetn(hresetn), .tx_valid(tx_valid), .tx_ident(tx_ident),
      .tx_ext(tx_ext), .tx_rtr(tx_rtr), .tx_dlc(tx_dlc), .tx_data(tx_data),
      .ack_dly(ack_dly), .tx_done(tx_done), .n_sent(n_sent), .last_f(last_f));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      @(posedge hclk);
   endtask : xfer

   task automatic post(input logic [31:0] id, klen, dlo, sz);
      xfer(1'b1, cqf_pkg::REG_ID, id);
      xfer(1'b1, cqf_pkg::REG_KLEN, klen);
      xfer(1'b1, cqf_pkg::REG_DLO, dlo);
      xfer(1'b1, cqf_pkg::REG_DHI, 32'h88776655);
      xfer(1'b1, cqf_pkg::REG_SUBMIT, sz);
   endtask : post

   task automatic wait_sent(input logic [7:0] n);
      while (n_sent !== n) @(negedge hclk);
      @(posedge hclk);
   endtask : wait_sent

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   initial begin
      #200000;
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      ack_dly = 8'h05;
      errors = 0;
      checks_done = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, cqf_pkg::REG_STATUS, 32'h0);
      `CHK(r, 32'h00000005)
      xfer(1'b0, cqf_pkg::REG_CTRL, 32'h0);
      `CHK(r, cqf_pkg::CTRL_RESET)
      `CHK(irq, 1'b0)
      `CHK(hresp, 1'b0)
      $display("test reset done");
      xfer(1'b1, cqf_pkg::REG_INT_MASK, 32'h7);
      post(32'h00000123, 32'h00000600, 32'h44332211, 32'h18);
      xfer(1'b0, cqf_pkg::REG_STATUS, 32'h0);
      `CHK(r[1:0], 2'h2)
      wait_sent(8'h01);
      `CHK(last_f, {2'b00, 29'h123, 4'h6, 64'h0000665544332211})
      repeat (3) @(negedge hclk);
      `CHK(irq, 1'b1)
      @(posedge hclk);
      xfer(1'b0, cqf_pkg::REG_STATUS, 32'h0);
      `CHK(r[2:0], 3'b101)
      xfer(1'b0, cqf_pkg::REG_INT_STAT, 32'h0);
      `CHK(r[2:0], 3'b001)
      repeat (2) @(negedge hclk);
      `CHK(irq, 1'b0)
      @(posedge hclk);
      post(32'h2ABCDEF1, 32'h00000501, 32'h44332211, 32'h18);
      wait_sent(8'h02);
      `CHK(last_f, {2'b11, 29'h0ABCDEF1, 4'h5, 64'h0})
      $display("test frame kinds done");
      post(32'h1, 32'h00000900, 32'h1, 32'h18);
      xfer(1'b0, cqf_pkg::REG_STATUS, 32'h0);
      `CHK(r[9:8], cqf_pkg::RES_KIND)
      post(32'h1, 32'h00000100, 32'h1, 32'h17);
      xfer(1'b0, cqf_pkg::REG_STATUS, 32'h0);
      `CHK(r[9:8], cqf_pkg::RES_SIZE)
      post(32'h1, 32'h00000102, 32'h1, 32'h18);
      xfer(1'b0, cqf_pkg::REG_STATUS, 32'h0);
      `CHK(r[9:8], cqf_pkg::RES_KIND)
      xfer(1'b0, cqf_pkg::REG_INT_STAT, 32'h0);
      `CHK(r[2], 1'b1)
      `CHK(n_sent, 8'h02)
      $display("test rejects done");
      ack_dly <= 8'hC8;
      for (int k = 1; k <= 10; k++) post(32'(k), 32'h00000100, 32'(k), 32'h18);
      xfer(1'b0, cqf_pkg::REG_STATUS, 32'h0);
      `CHK(r[9:8], cqf_pkg::RES_OVF)
      `CHK(r[7:4], 4'h8)
      xfer(1'b0, cqf_pkg::REG_INT_STAT, 32'h0);
      `CHK(r[1], 1'b1)
      ack_dly <= 8'h01;
      for (int k = 1; k <= 9; k++) begin
         wait_sent(8'(2 + k));
         `CHK(last_f.ident, 29'(k))
      end
      repeat (40) @(posedge hclk);
      `CHK(n_sent, 8'h0B)
      $display("test fifo overflow done");
      xfer(1'b1, cqf_pkg::REG_CTRL, 32'h0);
      xfer(1'b0, cqf_pkg::REG_INT_STAT, 32'h0);
      ack_dly <= 8'hC8;
      for (int k = 16; k <= 18; k++) post(32'(k), 32'h00000100, 32'(k), 32'h18);
      xfer(1'b0, cqf_pkg::REG_STATUS, 32'h0);
      `CHK(r[9:8], cqf_pkg::RES_OK)
      xfer(1'b0, cqf_pkg::REG_INT_STAT, 32'h0);
      `CHK(r[1], 1'b0)
      ack_dly <= 8'h01;
      wait_sent(8'h0D);
      `CHK(last_f.ident, 29'h12)
      repeat (40) @(posedge hclk);
      `CHK(n_sent, 8'h0D)
      $display("test zero depth done");
      ack_dly <= 8'h02;
      xfer(1'b1, cqf_pkg::REG_PERIOD, 32'h00000019);
      xfer(1'b0, cqf_pkg::REG_PERIOD, 32'h0);
      `CHK(r, 32'h00000019)
      xfer(1'b1, cqf_pkg::REG_CTRL, 32'h81);
      post(32'h55, 32'h00000100, 32'h55, 32'h18);
      base = n_sent;
      wait_sent(base + 8'h02);
      `CHK(last_f.ident, 29'h55)
      wait_sent(base + 8'h03);
      `CHK(last_f.ident, 29'h55)
      post(32'h66, 32'h00000100, 32'h66, 32'h18);
      base = n_sent;
      wait_sent(base + 8'h02);
      `CHK(last_f.ident, 29'h66)
      $display("test periodic done");
      give_verdict();
   end
endmodule : cqf_top_tb
